// ===== inc/wake_timer_pkg.sv
/*
 * constants, register map and field layouts of the wake-up timer block.
 * assumes a 20 MHz system clock and low-frequency oscillator levels that
 * arrive synchronous to it.
 */
package wake_timer_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CFG_HIGH = 10'h30c;
    localparam logic [9:0] IDX_CFG_LOW = 10'h30d;
    localparam logic [9:0] IDX_RELOAD_UPPER = 10'h30e;
    localparam logic [9:0] IDX_RELOAD_LOWER = 10'h30f;
    localparam logic [9:0] IDX_FLAG_CLEAR = 10'h310;
    localparam logic [9:0] IDX_STATUS = 10'h311;
    localparam int ADDR_W = 12;

    // field positions
    localparam int FC_CLEAR_BIT = 0;
    localparam int FC_CAL_BIT = 1;
    localparam int ST_LIVE_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_COLD_BIT = 2;

    // reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RELOAD_BYTE_RESET = 8'h00;
    localparam logic COLD_FLAG_RESET = 1'b1;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // tick divider per prescaler code
    localparam logic [16:0] TICK_DIV [8] = '{17'h00001, 17'h00004, 17'h00008,
        17'h00010, 17'h00080, 17'h00400, 17'h02000, 17'h10000};

    typedef struct packed {
        logic reserved;
        logic [3:0] rc_coarse_tune;
        logic [2:0] tick_divider_sel;
    } cfg_high_t;

    typedef struct packed {
        logic reserved7;
        logic rc_osc_enable;
        logic crystal_osc_enable;
        logic timer_clock_select;
        logic retention_ram_power;
        logic [1:0] reserved21;
        logic wake_on_timeout_arm;
    } cfg_low_t;

    typedef enum {CH_IDLE, CH_RESP} chan_state_t;

endpackage

// ===== core/wakeup_timer_control.sv
/*
 * wake-up timer: axi4-lite register slave, prescaler, 16-bit reload
 * down-counter, timeout flags and oscillator / retention controls.
 * assumes oscillator levels synchronous to clk and one axi master.
 */
`timescale 1ns/1ps
module wakeup_timer_control
    import wake_timer_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // low-frequency oscillator levels
    input wire logic rc_osc_level,
    input wire logic crystal_osc_level,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // controls to the analog side
    output logic rc_osc_enable,
    output logic crystal_osc_enable,
    output logic retention_ram_power,
    output logic [3:0] rc_coarse_tune,
    output logic [3:0] rc_tune_state,
    output logic rc_cal_enable,
    // wake-up
    output logic timeout_live_event,
    output logic wake_request
);

    cfg_high_t cfg_high_r;
    cfg_low_t cfg_low_r;
    logic [7:0] upper_pending_r;
    logic [15:0] reload_count_r;
    logic [15:0] count_r;
    logic [15:0] presc_cnt_r;
    logic osc_prev_r;
    logic live_r;
    logic timeout_latched_flag_r;
    logic cold_start_flag_r;
    logic rc_cal_enable_r;
    logic wake_r;
    logic [3:0] tune_state_r;
    logic aw_got_r, w_got_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    chan_state_t wr_state_r;

    // write channel handshakes; address and data may come in either order
    logic aw_hs, w_hs, aw_have, w_have, do_write, b_done;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic [9:0] wr_idx;
    logic wr_hit;
    assign aw_hs = s_axi_awvalid && awready_r;
    assign w_hs = s_axi_wvalid && wready_r;
    assign aw_have = aw_got_r || aw_hs;
    assign w_have = w_got_r || w_hs;
    assign do_write = clk_en && aw_have && w_have && (wr_state_r == CH_IDLE);
    assign b_done = bvalid_r && s_axi_bready;
    assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
    assign wr_lane0 = w_got_r ? w_strb_r[0] : s_axi_wstrb[0];
    assign wr_idx = wr_addr[ADDR_W-1:2];
    assign wr_hit = (wr_idx >= IDX_CFG_HIGH) && (wr_idx <= IDX_STATUS);

    // strobes of the single-byte registers; only lane 0 carries data
    logic we_cfg_high, we_cfg_low, we_upper, we_lower, we_flag;
    assign we_cfg_high = do_write && wr_lane0 && (wr_idx == IDX_CFG_HIGH);
    assign we_cfg_low = do_write && wr_lane0 && (wr_idx == IDX_CFG_LOW);
    assign we_upper = do_write && wr_lane0 && (wr_idx == IDX_RELOAD_UPPER);
    assign we_lower = do_write && wr_lane0 && (wr_idx == IDX_RELOAD_LOWER);
    assign we_flag = do_write && wr_lane0 && (wr_idx == IDX_FLAG_CLEAR);

    // write channel state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            wr_state_r <= CH_IDLE;
        end
        else if (clk_en)
        begin
            case (wr_state_r)
                CH_IDLE:
                begin
                    if (do_write)
                    begin
                        aw_got_r <= 1'b0;
                        w_got_r <= 1'b0;
                        awready_r <= 1'b0;
                        wready_r <= 1'b0;
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                        wr_state_r <= CH_RESP;
                    end
                    else
                    begin
                        if (aw_hs)
                        begin
                            aw_got_r <= 1'b1;
                            aw_addr_r <= s_axi_awaddr;
                        end
                        if (w_hs)
                        begin
                            w_got_r <= 1'b1;
                            w_data_r <= s_axi_wdata;
                            w_strb_r <= s_axi_wstrb;
                        end
                        awready_r <= !aw_have;
                        wready_r <= !w_have;
                    end
                end
                CH_RESP:
                begin
                    if (b_done)
                    begin
                        bvalid_r <= 1'b0;
                        awready_r <= 1'b1;
                        wready_r <= 1'b1;
                        wr_state_r <= CH_IDLE;
                    end
                end
                default: wr_state_r <= CH_IDLE;
            endcase
        end
    end

    // read channel; write-only registers read back as zero
    logic [9:0] rd_idx;
    logic [31:0] rd_word;
    logic rd_hit;
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];
    assign rd_hit = (rd_idx >= IDX_CFG_HIGH) && (rd_idx <= IDX_STATUS);
    always_comb
    begin
        rd_word = '0;
        if (rd_idx == IDX_FLAG_CLEAR)
            rd_word[FC_CAL_BIT] = rc_cal_enable_r;
        if (rd_idx == IDX_STATUS)
        begin
            rd_word[ST_LIVE_BIT] = live_r;
            rd_word[ST_LATCH_BIT] = timeout_latched_flag_r;
            rd_word[ST_COLD_BIT] = cold_start_flag_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && arready_r)
            begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
            begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
            else if (!rvalid_r)
                arready_r <= 1'b1;
        end
    end

    // configuration registers; high applies at once, low order is software's job
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_high_r <= cfg_high_t'(CFG_RESET);
            cfg_low_r <= cfg_low_t'(CFG_RESET);
            rc_cal_enable_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (we_cfg_high)
                cfg_high_r <= cfg_high_t'(wr_data[7:0]);
            if (we_cfg_low)
                cfg_low_r <= cfg_low_t'(wr_data[7:0]);
            if (we_flag)
                rc_cal_enable_r <= wr_data[FC_CAL_BIT];
        end
    end

    // reload value; upper byte waits for the lower write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            upper_pending_r <= RELOAD_BYTE_RESET;
            reload_count_r <= {RELOAD_BYTE_RESET, RELOAD_BYTE_RESET};
        end
        else if (clk_en)
        begin
            if (we_upper)
                upper_pending_r <= wr_data[7:0];
            if (we_lower)
                reload_count_r <= {upper_pending_r, wr_data[7:0]};
        end
    end

    // base tick from the selected oscillator's rising edge
    logic osc_level, timer_on, base_tick, presc_tick;
    logic [16:0] div_now;
    assign osc_level = cfg_low_r.timer_clock_select ? rc_osc_level : crystal_osc_level;
    assign timer_on = cfg_low_r.timer_clock_select ? cfg_low_r.rc_osc_enable
                                                   : cfg_low_r.crystal_osc_enable;
    assign base_tick = timer_on && osc_level && !osc_prev_r;
    assign div_now = TICK_DIV[cfg_high_r.tick_divider_sel];
    // compare with >= so a divider lowered mid-count ticks at once, not after a 16-bit wrap
    assign presc_tick = base_tick && ({1'b0, presc_cnt_r} >= div_now - 17'h00001);

    // prescaler and down-counter; a lower write restarts the count
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_prev_r <= 1'b0;
            presc_cnt_r <= '0;
            count_r <= '0;
        end
        else if (clk_en)
        begin
            osc_prev_r <= osc_level;
            if (presc_tick)
                presc_cnt_r <= '0;
            else if (base_tick)
                presc_cnt_r <= presc_cnt_r + 16'h0001;
            if (we_lower)
                count_r <= {upper_pending_r, wr_data[7:0]};
            else if (presc_tick)
                count_r <= (count_r == 16'h0000) ? reload_count_r
                                                 : count_r - 16'h0001;
        end
    end

    // timeout event and flags; a new event beats a simultaneous clear
    logic live_nxt, timeout_hit, flag_clr;
    assign live_nxt = timer_on && (count_r == 16'h0000);
    assign timeout_hit = live_nxt && !live_r;
    assign flag_clr = we_flag && wr_data[FC_CLEAR_BIT];
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            live_r <= 1'b0;
            timeout_latched_flag_r <= 1'b0;
            cold_start_flag_r <= COLD_FLAG_RESET;
            wake_r <= 1'b0;
        end
        else if (clk_en)
        begin
            live_r <= live_nxt;
            wake_r <= timeout_hit && cfg_low_r.wake_on_timeout_arm;
            if (timeout_hit)
                timeout_latched_flag_r <= 1'b1;
            else if (flag_clr)
                timeout_latched_flag_r <= 1'b0;
            if (flag_clr)
                cold_start_flag_r <= 1'b0;
        end
    end

    // coarse tune code to oscillator state 1..10; other codes give 0
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            tune_state_r <= 4'h0;
        else if (clk_en)
        begin
            case (cfg_high_r.rc_coarse_tune)
                4'h0: tune_state_r <= 4'ha;
                4'h1: tune_state_r <= 4'h9;
                4'h8: tune_state_r <= 4'h8;
                4'h9: tune_state_r <= 4'h7;
                4'hc: tune_state_r <= 4'h6;
                4'hd: tune_state_r <= 4'h5;
                4'he: tune_state_r <= 4'h4;
                4'hf: tune_state_r <= 4'h3;
                4'h6: tune_state_r <= 4'h2;
                4'h7: tune_state_r <= 4'h1;
                default: tune_state_r <= 4'h0;
            endcase
        end
    end

    // outputs straight from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign rc_osc_enable = cfg_low_r.rc_osc_enable;
    assign crystal_osc_enable = cfg_low_r.crystal_osc_enable;
    assign retention_ram_power = cfg_low_r.retention_ram_power;
    assign rc_coarse_tune = cfg_high_r.rc_coarse_tune;
    assign rc_tune_state = tune_state_r;
    assign rc_cal_enable = rc_cal_enable_r;
    assign timeout_live_event = live_r;
    assign wake_request = wake_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_upper_held_pending: assert property (we_upper && !we_lower |=> $stable(reload_count_r))
        else $error("upper byte took effect without lower write");
    a_lower_joins_reload: assert property (we_lower |=> reload_count_r == {$past(upper_pending_r), $past(wr_data[7:0])})
        else $error("reload not joined from pending upper and lower");
    a_reload_at_zero: assert property (clk_en && presc_tick && !we_lower && count_r == 16'h0000 |=> count_r == $past(reload_count_r))
        else $error("counter did not reload at zero");
    a_count_steps: assert property (clk_en && !presc_tick && !we_lower |=> $stable(count_r))
        else $error("counter moved without prescaler tick");
    a_live_at_zero: assert property (clk_en |=> live_r == ($past(timer_on) && $past(count_r) == 16'h0000))
        else $error("live event not tied to zero count");
    a_wake_armed: assert property ($rose(wake_r) |-> $past(cfg_low_r.wake_on_timeout_arm) && $past(timeout_hit))
        else $error("wake without arm or timeout");
    a_flag_latches: assert property (clk_en && timeout_hit |=> timeout_latched_flag_r [*2])
        else $error("timeout flag failed to latch or hold");
    a_clear_flags: assert property (clk_en && flag_clr && !timeout_hit |=> !timeout_latched_flag_r && !cold_start_flag_r)
        else $error("flag clear did not clear both flags");
    a_cal_enable: assert property (we_flag |=> rc_cal_enable_r == $past(wr_data[FC_CAL_BIT]))
        else $error("calibration enable not written");
    a_tune_center: assert property (clk_en && cfg_high_r.rc_coarse_tune == 4'hd |=> tune_state_r == 4'h5)
        else $error("nominal tune code not state 5");
    a_ram_power: assert property (we_cfg_low |=> retention_ram_power == $past(wr_data[3]))
        else $error("retention power not following bit 3");
    a_write_answers: assert property (do_write |=> bvalid_r)
        else $error("write not answered");

    c_wake: cover property (wake_r);
    c_reload_pair: cover property (we_upper ##[1:20] we_lower);
    c_clear_race: cover property (timeout_hit && flag_clr);
    c_bad_addr: cover property (bvalid_r && bresp_r == RESP_SLVERR);

endmodule

// ===== dv/tb_wakeup_timer_control.sv
/*
 * self-checking bench for the wake-up timer: register writes over axi4-lite,
 * coarse tune decode, oscillator controls, reload pairing, prescaler and flags.
 * assumes the design's package and a 20 MHz clock; oscillators are toggled here.
 */
`timescale 1ns/1ps
module tb_wakeup_timer_control;
    import wake_timer_pkg::*;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic rc_osc_level = 1'b0;
    logic crystal_osc_level = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [ADDR_W-1:0] araddr = '0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic rc_osc_enable, crystal_osc_enable, retention_ram_power, rc_cal_enable;
    logic [3:0] rc_coarse_tune, rc_tune_state;
    logic timeout_live_event, wake_request;
    logic run_rc = 1'b0;
    logic run_x = 1'b0;
    logic ph = 1'b0;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    wakeup_timer_control uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .rc_osc_level(rc_osc_level), .crystal_osc_level(crystal_osc_level),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rc_osc_enable(rc_osc_enable),
        .crystal_osc_enable(crystal_osc_enable), .retention_ram_power(retention_ram_power),
        .rc_coarse_tune(rc_coarse_tune), .rc_tune_state(rc_tune_state),
        .rc_cal_enable(rc_cal_enable), .timeout_live_event(timeout_live_event),
        .wake_request(wake_request));

    // 50 ns period
    always #25 clk = ~clk;

    // oscillators rise once every four clocks, so a divide-by-1 tick is 4 cycles
    always @(posedge clk)
    begin
        ph <= ~ph;
        if (ph && run_x) crystal_osc_level <= ~crystal_osc_level;
        if (ph && run_rc) rc_osc_level <= ~rc_osc_level;
    end

    // hang guard, far above the longest expected run
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            $display("ERROR %0t: run did not finish in time", $time);
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    function automatic logic [ADDR_W-1:0] baddr(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    // both channels offered together; each released at its own taking edge
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
        input logic [1:0] exp_resp);
        bit aw_done, w_done;
        int n;
        aw_done = 0;
        w_done = 0;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done) && n < 100)
        begin
            @(posedge clk);
            n++;
            if (awready === 1'b1 && !aw_done)
            begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done)
            begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        check({30'h0, bresp}, {30'h0, exp_resp}, "write response");
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic read_check(input logic [9:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(baddr(idx), d, r);
        check(d, exp, msg);
    endtask

    // cycles between two rising live events, and wake pulses in between
    task automatic measure(output int per, output int wakes);
        int n;
        logic was;
        n = 0;
        per = 0;
        wakes = 0;
        was = 1'b1;
        @(negedge clk);
        while (timeout_live_event === 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        while (timeout_live_event !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        // stop at the next low-to-high step of the live event
        while (per < 5000)
        begin
            @(negedge clk);
            per++;
            if (wake_request === 1'b1)
                wakes++;
            if (timeout_live_event === 1'b1 && was === 1'b0)
                break;
            was = timeout_live_event;
        end
    endtask

    task automatic t_reset_and_map;
        logic [31:0] d;
        logic [1:0] r;
        check({28'h0, rc_osc_enable, crystal_osc_enable, retention_ram_power, rc_cal_enable},
            32'h0, "outputs after reset");
        read_check(IDX_STATUS, 32'h4, "status after reset");
        read_check(IDX_CFG_HIGH, 32'h0, "write-only read");
        axi_read(12'h800, d, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read resp");
        axi_write(12'h804, 8'hff, RESP_SLVERR);
    endtask

    task automatic t_coarse_tune;
        logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf, 4'h6, 4'h7};
        for (int i = 0; i < 10; i++)
        begin
            axi_write(baddr(IDX_CFG_HIGH), {1'b0, codes[i], 3'h0}, RESP_OKAY);
            axi_write(baddr(IDX_CFG_LOW), 8'h00, RESP_OKAY);
            @(negedge clk);
            check({28'h0, rc_coarse_tune}, {28'h0, codes[i]}, "coarse field");
            check({28'h0, rc_tune_state}, 32'(10 - i), "tune state");
        end
    endtask

    task automatic t_controls;
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h68, RESP_OKAY);
        @(negedge clk);
        check({29'h0, rc_osc_enable, crystal_osc_enable, retention_ram_power},
            32'h7, "osc on");
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h20, RESP_OKAY);
        @(negedge clk);
        check({29'h0, rc_osc_enable, crystal_osc_enable, retention_ram_power},
            32'h2, "ram off");
        axi_write(baddr(IDX_FLAG_CLEAR), 8'h02, RESP_OKAY);
        @(negedge clk);
        check({31'h0, rc_cal_enable}, 32'h1, "cal enable");
        read_check(IDX_FLAG_CLEAR, 32'h2, "flag clear readback");
    endtask

    task automatic t_timer;
        int per, wakes;
        logic [2:0] code;
        axi_write(baddr(IDX_RELOAD_UPPER), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_RELOAD_LOWER), 8'h03, RESP_OKAY);
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h21, RESP_OKAY);
        run_x <= 1'b1;
        measure(per, wakes);
        check(per, 16, "period reload 3");
        check(wakes, 1, "armed wake pulse");
        axi_write(baddr(IDX_RELOAD_UPPER), 8'h01, RESP_OKAY);
        measure(per, wakes);
        check(per, 16, "upper byte pending");
        axi_write(baddr(IDX_RELOAD_LOWER), 8'h00, RESP_OKAY);
        measure(per, wakes);
        check(per, 257 * 4, "period reload 0x100");
        axi_write(baddr(IDX_RELOAD_UPPER), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_RELOAD_LOWER), 8'h03, RESP_OKAY);
        for (int c = 1; c < 4; c++)
        begin
            code = 3'(c);
            axi_write(baddr(IDX_CFG_HIGH), {5'h00, code}, RESP_OKAY);
            axi_write(baddr(IDX_CFG_LOW), 8'h21, RESP_OKAY);
            measure(per, wakes);
            check(per, 16 * int'(TICK_DIV[c]), "prescaled period");
        end
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h20, RESP_OKAY);
        measure(per, wakes);
        check(wakes, 0, "disarmed no wake");
    endtask

    task automatic t_flags_and_rc;
        int per, wakes;
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h00, RESP_OKAY);
        read_check(IDX_STATUS, 32'h6, "flags latched");
        axi_write(baddr(IDX_FLAG_CLEAR), 8'h01, RESP_OKAY);
        read_check(IDX_STATUS, 32'h0, "flags cleared");
        check({31'h0, rc_cal_enable}, 32'h0, "cal disabled");
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h30, RESP_OKAY);
        repeat (100) @(negedge clk);
        check({31'h0, timeout_live_event}, 32'h0, "rc selected but off");
        run_x <= 1'b0;
        run_rc <= 1'b1;
        axi_write(baddr(IDX_CFG_HIGH), 8'h00, RESP_OKAY);
        axi_write(baddr(IDX_CFG_LOW), 8'h51, RESP_OKAY);
        measure(per, wakes);
        check(per, 16, "rc clocked period");
        // live just rose; with the enable low it must not fall after its one tick
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (40) @(negedge clk);
        check({31'h0, timeout_live_event}, 32'h1, "state frozen while disabled");
        check({31'h0, wake_request}, 32'h0, "no wake while disabled");
        @(posedge clk);
        clk_en <= 1'b1;
    endtask

    task automatic complete_run;
        $display("errors %0d, comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset_and_map();
        t_coarse_tune();
        t_controls();
        t_timer();
        t_flags_and_rc();
        complete_run();
    end
endmodule
